/* File: sarcv_regs.svh */
// Register offsets, field positions and reset values of the converter setup block
// Assumes inclusion by the package of this block only; the design modules use its macros through the package
`ifndef SARCV_REGS_SVH
`define SARCV_REGS_SVH
`define SARCV_OFS_BANK 8'h00
`define SARCV_OFS_UNUSED1 8'h01
`define SARCV_OFS_SETUP 8'h02
`define SARCV_BANK_RST 8'h00
`define SARCV_UNUSED1_RST 8'h00
`define SARCV_SETUP_RST 8'h00
`define SARCV_BIT_STOP 7
`define SARCV_RES_HI 6
`define SARCV_RES_LO 5
`define SARCV_DIV_HI 4
`define SARCV_DIV_LO 3
`define SARCV_BIT_FILT 2
`define SARCV_AVG_HI 1
`define SARCV_AVG_LO 0
`define SARCV_CNT_W 4
`define SARCV_CNT_ZERO 4'h0
`define SARCV_CNT_ONE 4'h1
`define SARCV_AVG_MEAN1 5'h04
`define SARCV_AVG_MEAN2 5'h08
`define SARCV_AVG_MEAN3 5'h10
`define SARCV_AVG_MED1 5'h05
`define SARCV_AVG_MED2 5'h09
`define SARCV_AVG_MED3 5'h0f
`define SARCV_AVG_NONE 5'h01
`define SARCV_RES_8 5'h08
`define SARCV_RES_10 5'h0a
`define SARCV_RES_12 5'h0c
`endif

/* File: sarcv_pkg.sv */
// Types shared by the converter setup block
// Assumes sarcv_regs.svh sits in the include path
package sarcv_pkg;
`include "sarcv_regs.svh"
    // Resolution field codes
    typedef enum logic [1:0] {
        SARCV_RES12A = 2'h0,
        SARCV_RES8 = 2'h1,
        SARCV_RES10 = 2'h2,
        SARCV_RES12B = 2'h3
    } sarcv_res_t;
    // Converter setup register layout
    typedef struct packed {
        logic stop;
        sarcv_res_t res;
        logic [1:0] div;
        logic median;
        logic [1:0] avg;
    } sarcv_setup_t;
    // Decoded settings sent to the converter core
    typedef struct packed {
        logic power_down;
        logic [4:0] res_bits;
        logic median;
        logic avg_on;
        logic [4:0] avg_count;
    } sarcv_cfg_t;
    // Scan sequencer states
    typedef enum logic [1:0] {
        SARCV_IDLE,
        SARCV_SCAN
    } sarcv_state_t;
endpackage

/* File: sarcv_clkdiv.sv */
// Conversion clock enable divider: one pulse every 1, 2, 4 or 8 cycles
// Assumes a single clock domain and a synchronous active-low reset
module sarcv_clkdiv
    import sarcv_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic run_in,
    input wire logic [1:0] div_sel_in,
    output logic conv_en_out
);
    logic [`SARCV_CNT_W-1:0] cnt_r; // Cycles since last pulse
    logic [`SARCV_CNT_W-1:0] cnt_nxt;
    logic conv_en_r; // Registered enable pulse
    logic conv_en_nxt;
    logic [`SARCV_CNT_W-1:0] limit; // Divide ratio minus one

    // Next count and pulse
    always_comb begin
        limit = `SARCV_CNT_W'((`SARCV_CNT_ONE << div_sel_in) - `SARCV_CNT_ONE);
        cnt_nxt = cnt_r;
        conv_en_nxt = 1'b0;
        if (!run_in) begin
            // Held idle while powered down
            cnt_nxt = `SARCV_CNT_ZERO;
        end else if (cnt_r >= limit) begin
            cnt_nxt = `SARCV_CNT_ZERO;
            conv_en_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + `SARCV_CNT_ONE;
        end
    end

    // State registers
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            cnt_r <= `SARCV_CNT_ZERO;
            conv_en_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            conv_en_r <= conv_en_nxt;
        end
    end

    assign conv_en_out = conv_en_r;
endmodule

/* File: sarcv_setup_regs.sv */
// Converter setup registers: bank select, reserved slot and converter setup
// Assumes a same-clock register port from the serial control interface
// Notes on behaviour
// - Bank select stores any written byte
// - Stop bit aborts conversion, powers converter down
// - Resolution codes give 12, 8, 10, 12 bits
// - Divider 1/2/4/8, conversion clock only
// - Filter bit picks mean or median
// - Averaging depth 4/8/16 or 5/9/15
// - Scan runs until pen lifts or stop
module sarcv_setup_regs
    import sarcv_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic wr_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic pen_down_in,
    input wire logic scan_start_in,
    output logic [7:0] rdata_out,
    output logic [7:0] bank_out,
    output sarcv_cfg_t cfg_out,
    output logic conv_en_out,
    output logic scanning_out,
    output logic abort_out
);
    logic [7:0] bank_r; // Register bank in use
    logic [7:0] bank_nxt;
    logic [7:0] unused1_r; // Reserved slot contents
    logic [7:0] unused1_nxt;
    sarcv_setup_t setup_r; // Converter setup
    sarcv_setup_t setup_nxt;
    logic [7:0] rdata_r; // Read data
    logic [7:0] rdata_nxt;
    sarcv_cfg_t cfg_r; // Decoded settings
    sarcv_cfg_t cfg_nxt;
    sarcv_state_t state_r; // Scan sequencer
    sarcv_state_t state_nxt;
    logic abort_r; // Abort pulse
    logic abort_nxt;
    logic pen_meta_r; // Pen synchroniser first stage
    logic pen_sync_r; // Pen synchroniser second stage
    logic scanning_r; // Registered scan flag for the output pin
    logic div_en; // Conversion clock enable

    // Register writes and read mux
    always_comb begin
        bank_nxt = bank_r;
        unused1_nxt = unused1_r;
        setup_nxt = setup_r;
        rdata_nxt = 8'h00;
        if (wr_en_in) begin
            unique case (addr_in)
                `SARCV_OFS_BANK: bank_nxt = wdata_in;
                // reserved slot, loaded with SARCV_UNUSED1_RST by reset; stores any write
                `SARCV_OFS_UNUSED1: unused1_nxt = wdata_in;
                `SARCV_OFS_SETUP: setup_nxt = sarcv_setup_t'(wdata_in);
                default: bank_nxt = bank_r; // Unmapped: ignored
            endcase
        end
        unique case (addr_in)
            `SARCV_OFS_BANK: rdata_nxt = bank_r;
            `SARCV_OFS_UNUSED1: rdata_nxt = unused1_r;
            `SARCV_OFS_SETUP: rdata_nxt = setup_r;
            default: rdata_nxt = 8'h00; // Unmapped reads zero
        endcase
    end

    // Decode of setup fields
    always_comb begin
        cfg_nxt.power_down = setup_r.stop;
        cfg_nxt.median = setup_r.median;
        unique case (setup_r.res)
            SARCV_RES8: cfg_nxt.res_bits = `SARCV_RES_8;
            SARCV_RES10: cfg_nxt.res_bits = `SARCV_RES_10;
            SARCV_RES12A, SARCV_RES12B: cfg_nxt.res_bits = `SARCV_RES_12;
        endcase
        cfg_nxt.avg_on = (setup_r.avg != 2'h0);
        unique case (setup_r.avg)
            2'h0: cfg_nxt.avg_count = `SARCV_AVG_NONE;
            2'h1: cfg_nxt.avg_count = setup_r.median ? `SARCV_AVG_MED1 : `SARCV_AVG_MEAN1;
            2'h2: cfg_nxt.avg_count = setup_r.median ? `SARCV_AVG_MED2 : `SARCV_AVG_MEAN2;
            2'h3: cfg_nxt.avg_count = setup_r.median ? `SARCV_AVG_MED3 : `SARCV_AVG_MEAN3;
        endcase
    end

    // Scan sequencer next state
    always_comb begin
        state_nxt = state_r;
        abort_nxt = 1'b0;
        unique case (state_r)
            SARCV_IDLE: begin
                if (scan_start_in && !setup_r.stop && pen_sync_r) begin
                    state_nxt = SARCV_SCAN;
                end
            end
            SARCV_SCAN: begin
                // run until pen lift or stop
                if (setup_r.stop || !pen_sync_r) begin
                    state_nxt = SARCV_IDLE;
                    abort_nxt = setup_r.stop;
                end
            end
        endcase
    end

    // Registers
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            bank_r <= `SARCV_BANK_RST;
            unused1_r <= `SARCV_UNUSED1_RST;
            setup_r <= sarcv_setup_t'(`SARCV_SETUP_RST);
            rdata_r <= 8'h00;
            cfg_r <= '0;
            state_r <= SARCV_IDLE;
            abort_r <= 1'b0;
            pen_meta_r <= 1'b0;
            pen_sync_r <= 1'b0;
            scanning_r <= 1'b0;
        end else begin
            bank_r <= bank_nxt;
            unused1_r <= unused1_nxt;
            setup_r <= setup_nxt;
            rdata_r <= rdata_nxt;
            cfg_r <= cfg_nxt;
            state_r <= state_nxt;
            abort_r <= abort_nxt;
            pen_meta_r <= pen_down_in;
            pen_sync_r <= pen_meta_r;
            // Same timing as the state register, but a flop of its own
            scanning_r <= (state_nxt == SARCV_SCAN);
        end
    end

    sarcv_clkdiv u_div (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .run_in(!setup_r.stop),
        .div_sel_in(setup_r.div),
        .conv_en_out(div_en)
    );

    logic conv_en_r; // Enable gated by scan
    always_ff @(posedge ref_clk_in) begin
        if (!reset_n_in) begin
            conv_en_r <= 1'b0;
        end else begin
            conv_en_r <= div_en && (state_r == SARCV_SCAN);
        end
    end

    assign rdata_out = rdata_r;
    assign bank_out = bank_r;
    assign cfg_out = cfg_r;
    assign conv_en_out = conv_en_r;
    assign scanning_out = scanning_r;
    assign abort_out = abort_r;
endmodule

/* File: sarcv_setup_props.sv */
// Checker for the converter setup registers
// Assumes binding to sarcv_setup_regs, one clock domain
module sarcv_setup_props
    import sarcv_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic wr_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] bank_out,
    input wire sarcv_cfg_t cfg_out,
    input wire logic conv_en_out,
    input wire logic scanning_out,
    input wire logic abort_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    // Write strobe aimed at the setup register
    wire logic wr_setup = wr_en_in && addr_in == 8'h02;
    a_bank_store: assert property (
        wr_en_in && addr_in == 8'h00 |=> bank_out == $past(wdata_in))
        else $error("bank value not stored");
    a_stop_powers_down: assert property (
        wr_setup |-> ##2 cfg_out.power_down == $past(wdata_in[7], 2))
        else $error("power down does not follow stop bit");
    a_stop_ends_scan: assert property (
        wr_setup && wdata_in[7] |-> ##2 !scanning_out)
        else $error("scan still running after stop");
    a_abort_one_cycle: assert property (
        abort_out |-> !scanning_out ##1 !abort_out)
        else $error("abort pulse wrong");
    a_res_eight: assert property (
        wr_setup && wdata_in[6:5] == 2'h1 |-> ##2 cfg_out.res_bits == 5'h08)
        else $error("resolution code 01 not 8 bits");
    a_median_deep: assert property (
        wr_setup && wdata_in[2:0] == 3'h7 |-> ##2 cfg_out.median && cfg_out.avg_count == 5'h0f)
        else $error("median depth wrong");
    a_avg_off: assert property (
        wr_setup && wdata_in[1:0] == 2'h0 |-> ##2 !cfg_out.avg_on)
        else $error("averaging not disabled");
    a_conv_in_scan: assert property (
        conv_en_out |-> scanning_out || $past(scanning_out))
        else $error("conversion clock outside scan");
endmodule
bind sarcv_setup_regs sarcv_setup_props u_props (.*);

/* File: sarcv_setup_regs_bench.sv */
// Self-checking bench for the converter setup registers
// Assumes the design files and the checker are compiled before it
module sarcv_setup_regs_bench
    import sarcv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in = 0, reset_n_in = 0, wr_en_in = 0, pen_down_in = 0;
    logic scan_start_in = 0, rd_req = 0, rd_seen = 0;
    logic [7:0] addr_in = 0, wdata_in = 0, rdata_out, bank_out, d;
    sarcv_cfg_t cfg_out;
    logic conv_en_out, scanning_out, abort_out;
    int n_fail = 0, n_tests = 0, seed = 44830, i, k;
    logic [7:0] exp_q [$];
    // Expected resolution and averaging depth per code
    logic [7:0] res_tbl [4] = '{8'h0c, 8'h08, 8'h0a, 8'h0c};
    logic [7:0] avg_tbl [8] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h01, 8'h05, 8'h09, 8'h0f};
    always #10 ref_clk_in = ~ref_clk_in;
    sarcv_setup_regs dut (.*);
    // Compare and count
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // One register write
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk_in);
        wr_en_in <= 1'b1;
        addr_in <= a;
        wdata_in <= v;
        @(posedge ref_clk_in);
        wr_en_in <= 1'b0;
    endtask
    // One read, expectation queued
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_req <= 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk_in);
        rd_req <= 1'b0;
    endtask
    // Bounded wait on the scan flag
    task automatic wait_scan(input logic want);
        for (k = 0; k < 50 && scanning_out !== want; k++)
            @(negedge ref_clk_in);
        chk("scanning", 8'(want), 8'(scanning_out));
        if (scanning_out !== want)
            tally_and_finish();
    endtask
    task automatic start_scan();
        @(posedge ref_clk_in);
        pen_down_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        scan_start_in <= 1'b1;
        @(posedge ref_clk_in);
        scan_start_in <= 1'b0;
    endtask
    // Read data watcher
    always @(posedge ref_clk_in) rd_seen <= rd_req;
    always @(negedge ref_clk_in) begin
        if (rd_seen === 1'b1)
            chk("rdata", exp_q.pop_front(), rdata_out);
    end
    initial begin
        repeat (2) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        for (i = 0; i < 4; i++)
            rd(8'(i), 8'h00);
        chk("res_reset", 8'h0c, 8'(cfg_out.res_bits));
        for (i = 0; i < 6; i++) begin
            d = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($random(seed));
            wr(8'h00, d);
            rd(8'h00, d);
            chk("bank", d, bank_out);
        end
        wr(8'h01, 8'h00);
        rd(8'h01, 8'h00);
        wr(8'h03, 8'h5a);
        rd(8'h03, 8'h00);
        for (i = 0; i < 64; i++) begin
            d = {i[5], i[4:3], (i[4] ^ i[3]) ? 2'h2 : 2'h3, i[2:0]};
            wr(8'h02, d);
            repeat (2) @(negedge ref_clk_in);
            chk("pwr", 8'(d[7]), 8'(cfg_out.power_down));
            chk("res", res_tbl[d[6:5]], 8'(cfg_out.res_bits));
            chk("median", 8'(d[2]), 8'(cfg_out.median));
            chk("avg_on", 8'(d[1:0] != 2'h0), 8'(cfg_out.avg_on));
            chk("count", avg_tbl[d[2:0]], 8'(cfg_out.avg_count));
            rd(8'h02, d);
        end
        for (i = 0; i < 4; i++) begin
            wr(8'h02, {3'b001, i[1:0], 3'b000});
            start_scan();
            wait_scan(1'b1);
            for (k = 0; k < 50 && conv_en_out !== 1'b1; k++)
                @(negedge ref_clk_in);
            @(negedge ref_clk_in);
            for (k = 1; k < 50 && conv_en_out !== 1'b1; k++)
                @(negedge ref_clk_in);
            chk("period", 8'h01 << i, 8'(k));
            if (i < 2) begin
                wr(8'h02, {3'b101, i[1:0], 3'b000});
                repeat (2) @(negedge ref_clk_in);
                chk("abort", 8'h01, 8'(abort_out));
                start_scan();
                repeat (2) @(negedge ref_clk_in);
                chk("refused", 8'h00, 8'(scanning_out));
            end else begin
                @(posedge ref_clk_in);
                pen_down_in <= 1'b0;
                wait_scan(1'b0);
                chk("no_abort", 8'h00, 8'(abort_out));
            end
        end
        tally_and_finish();
    end
endmodule
